// >>> hdl/bdm_defs.vh
`ifndef BDM_DEFS_VH
`define BDM_DEFS_VH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define BDM_ADDR_W        16
`define BDM_DATA_W        32
`define BDM_BANKS         16
`define BDM_BANK_W        4
`define BDM_WORDS         65536
// Bank select: three top address bits plus the lowest one
`define BDM_PAIR_HI       15
`define BDM_PAIR_LO       13
`define BDM_ODD_BIT       0
// ----------------------------------------
// Clock
// ----------------------------------------
`define BDM_CLK_PERIOD_NS 25
// ----------------------------------------
// Spacing, loaded as cycles minus one
// ----------------------------------------
`define BDM_STD_SAME_GAP  2'h2
`define BDM_STD_DIFF_GAP  2'h1
`define BDM_FAST_SAME_GAP 2'h1
`define BDM_FAST_DIFF_GAP 2'h0
// ----------------------------------------
// Penalties in half clocks
// ----------------------------------------
`define BDM_PEN_W         6
`define BDM_HALF          6'h2
`define BDM_ONE_HALF      6'h1
`define BDM_REF_INTLV     6'h8
`define BDM_REF_NONINT    6'h6
`define BDM_HOST_DIFF_F   6'h2
`define BDM_HOST_DIFF_S   6'h4
`define BDM_HOST_SAME_F   6'h4
`define BDM_HOST_SAME_S   6'h6
`define BDM_IO_DIFF_F     6'h4
`define BDM_IO_DIFF_S     6'h5
`define BDM_IO_SAME_F     6'h6
`define BDM_IO_SAME_S     6'h7
// ----------------------------------------
// Read latency stages after the accepting edge
// ----------------------------------------
`define BDM_RD_STAGES     3
`endif

// >>> hdl/bdm_bank_timer.v
`include "bdm_defs.vh"
module bdm_bank_timer (
    // Clock and reset
    input  wire                    clk_in,
    input  wire                    reset_in,
    // Access issue
    input  wire                    issue_in,
    input  wire [`BDM_BANK_W-1:0]  issue_bank_in,
    input  wire                    fast_mode_in,
    // Query
    input  wire [`BDM_BANK_W-1:0]  query_bank_in,
    output wire                    free_out
);
    // ----------------------------------------
    // Per-bank busy counters and a shared spacing counter
    // ----------------------------------------
    reg  [1:0]             gap;
    wire [`BDM_BANKS-1:0]  bank_busy;
    wire [1:0]             same_gap = fast_mode_in ? `BDM_FAST_SAME_GAP : `BDM_STD_SAME_GAP;
    wire [1:0]             diff_gap = fast_mode_in ? `BDM_FAST_DIFF_GAP : `BDM_STD_DIFF_GAP;

    genvar b;
    generate
        for (b = 0; b < `BDM_BANKS; b = b + 1) begin : g_bank
            reg [1:0] count;
            always @(posedge clk_in) begin
                if (reset_in)
                    count <= 2'h0;
                else if (issue_in && (issue_bank_in == b))
                    count <= same_gap;
                else if (count != 2'h0)
                    count <= count - 2'h1;
            end
            assign bank_busy[b] = (count != 2'h0);
        end
    endgenerate

    always @(posedge clk_in) begin
        if (reset_in)
            gap <= 2'h0;
        else if (issue_in)
            gap <= diff_gap;
        else if (gap != 2'h0)
            gap <= gap - 2'h1;
    end

    assign free_out = !bank_busy[query_bank_in] && (gap == 2'h0);
endmodule // bdm_bank_timer

// >>> hdl/bdm_timing.v
// Operation
// - Interleaved refresh stalls four clocks
// - Non-interleaved refresh stalls three clocks
// - Host DMA other pair: one/two clocks
// - Host DMA same pair: two/three clocks
// - Second channel: 2/2.5, 3/3.5 clocks
// - Non-interleaved: DMA penalties one clock less
// - Sixteen 4K banks, top three plus lsb
// - Bank spacing: two different, three same; fast: one, two
// - Read data appears three cycles later
// - Address change plus load writes, alone reads
// - Busy bank stalls program until free
`include "bdm_defs.vh"
module bdm_timing (
    // Clock and reset
    input  wire                    clk_in,
    input  wire                    reset_in,
    // Memory speed
    input  wire                    fast_mode_in,
    // Address modification from the sequencer
    input  wire                    addr_set_in,
    input  wire                    addr_inc_in,
    input  wire                    addr_dec_in,
    input  wire [`BDM_ADDR_W-1:0]  addr_value_in,
    // Write data load
    input  wire                    write_load_in,
    input  wire [`BDM_DATA_W-1:0]  memory_write_input_in,
    // Refresh and DMA events
    input  wire                    refresh_req_in,
    input  wire                    host_dma_req_in,
    input  wire [`BDM_ADDR_W-1:0]  host_dma_addr_in,
    input  wire                    second_io_channel_req_in,
    input  wire [`BDM_ADDR_W-1:0]  second_io_channel_addr_in,
    // Outputs
    output reg  [`BDM_ADDR_W-1:0]  memory_address_register_out,
    output reg  [`BDM_DATA_W-1:0]  memory_read_output_out,
    output reg                     stall_out
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg  [`BDM_DATA_W-1:0]  mem [0:`BDM_WORDS-1];
    reg                     pending;
    reg                     pending_write;
    reg  [`BDM_ADDR_W-1:0]  pending_addr;
    reg  [`BDM_DATA_W-1:0]  pending_data;
    reg  [`BDM_BANK_W-1:0]  last_bank;
    reg                     non_interleaved;
    reg  [`BDM_PEN_W-1:0]   penalty;
    reg  [`BDM_DATA_W-1:0]  rd_stage1;
    reg  [`BDM_DATA_W-1:0]  rd_stage2;
    reg                     rd_valid1;
    reg                     rd_valid2;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    wire                    addr_mod = addr_set_in | addr_inc_in | addr_dec_in;
    wire                    new_req = addr_mod && !stall_out;
    reg  [`BDM_ADDR_W-1:0]  req_addr;
    always @* begin
        if (addr_set_in)
            req_addr = addr_value_in;
        else if (addr_inc_in)
            req_addr = memory_address_register_out + 16'h0001;
        else
            req_addr = memory_address_register_out - 16'h0001;
    end

    wire                    cand_valid = pending | new_req;
    wire [`BDM_ADDR_W-1:0]  cand_addr  = pending ? pending_addr : req_addr;
    wire                    cand_write = pending ? pending_write : write_load_in;
    wire [`BDM_DATA_W-1:0]  cand_data  = pending ? pending_data : memory_write_input_in;
    wire [`BDM_BANK_W-1:0]  cand_bank  = {cand_addr[`BDM_PAIR_HI:`BDM_PAIR_LO], cand_addr[`BDM_ODD_BIT]};

    wire                    bank_free;
    wire                    pen_active = (penalty >= `BDM_HALF);
    wire                    issue = cand_valid && bank_free && !pen_active;

    bdm_bank_timer u_timer (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .issue_in      (issue),
        .issue_bank_in (cand_bank),
        .fast_mode_in  (fast_mode_in),
        .query_bank_in (cand_bank),
        .free_out      (bank_free)
    );

    // ----------------------------------------
    // Penalty computation
    // ----------------------------------------
    wire [2:0] proc_pair = last_bank[`BDM_BANK_W-1:1];
    wire host_same = (host_dma_addr_in[`BDM_PAIR_HI:`BDM_PAIR_LO] == proc_pair);
    wire io_same   = (second_io_channel_addr_in[`BDM_PAIR_HI:`BDM_PAIR_LO] == proc_pair);
    reg  [`BDM_PEN_W-1:0] ref_pen;
    reg  [`BDM_PEN_W-1:0] host_pen;
    reg  [`BDM_PEN_W-1:0] io_pen;
    reg  [`BDM_PEN_W-1:0] next_penalty;
    always @* begin
        ref_pen  = 6'h0;
        host_pen = 6'h0;
        io_pen   = 6'h0;
        if (refresh_req_in)
            ref_pen = non_interleaved ? `BDM_REF_NONINT : `BDM_REF_INTLV;
        if (host_dma_req_in) begin
            if (host_same)
                host_pen = fast_mode_in ? `BDM_HOST_SAME_F : `BDM_HOST_SAME_S;
            else
                host_pen = fast_mode_in ? `BDM_HOST_DIFF_F : `BDM_HOST_DIFF_S;
            if (non_interleaved)
                host_pen = host_pen - `BDM_HALF;
        end
        if (second_io_channel_req_in) begin
            if (io_same)
                io_pen = fast_mode_in ? `BDM_IO_SAME_F : `BDM_IO_SAME_S;
            else
                io_pen = fast_mode_in ? `BDM_IO_DIFF_F : `BDM_IO_DIFF_S;
            if (non_interleaved)
                io_pen = io_pen - `BDM_HALF;
        end
        // one clock per cycle
        // Leftover half clock carries into the next event
        next_penalty = penalty + ref_pen + host_pen + io_pen - (pen_active ? `BDM_HALF : 6'h0);
    end

    // ----------------------------------------
    // Access sequencing
    // ----------------------------------------
    wire next_pending = cand_valid && !issue;

    always @(posedge clk_in) begin
        if (reset_in) begin
            pending                     <= 1'b0;
            pending_write               <= 1'b0;
            pending_addr                <= 16'h0000;
            pending_data                <= 32'h00000000;
            memory_address_register_out <= 16'h0000;
            last_bank                   <= 4'h0;
            non_interleaved             <= 1'b0;
            penalty                     <= 6'h0;
            stall_out                   <= 1'b0;
        end else begin
            pending <= next_pending;
            if (new_req) begin
                pending_write <= write_load_in;
                pending_addr  <= req_addr;
                pending_data  <= memory_write_input_in;
            end
            if (issue) begin
                memory_address_register_out <= cand_addr;
                last_bank                   <= cand_bank;
                non_interleaved             <= (cand_bank == last_bank);
            end
            penalty <= next_penalty;
            stall_out <= next_pending || (next_penalty >= `BDM_HALF);
        end
    end

    always @(posedge clk_in) begin
        if (issue && cand_write)
            mem[cand_addr] <= cand_data;
    end

    // ----------------------------------------
    // Read pipeline
    // ----------------------------------------
    // Writes leave the output alone so an earlier read stays usable
    // three cycle read latency
    always @(posedge clk_in) begin
        if (reset_in) begin
            rd_valid1              <= 1'b0;
            rd_valid2              <= 1'b0;
            rd_stage1              <= 32'h00000000;
            rd_stage2              <= 32'h00000000;
            memory_read_output_out <= 32'h00000000;
        end else begin
            rd_valid1 <= issue && !cand_write;
            rd_valid2 <= rd_valid1;
            if (issue && !cand_write)
                rd_stage1 <= mem[cand_addr];
            if (rd_valid1)
                rd_stage2 <= rd_stage1;
            if (rd_valid2)
                memory_read_output_out <= rd_stage2;
        end
    end
endmodule // bdm_timing

// >>> testbench/bdm_seq_model.sv
`include "bdm_defs.vh"
module bdm_seq_model (
    // Clock and hold-off
    input  wire                    clk_in,
    input  wire                    stall_in,
    // Request toward the timing block
    output logic                   set_out,
    output logic                   inc_out,
    output logic [`BDM_ADDR_W-1:0] value_out,
    output logic                   load_out,
    output logic [`BDM_DATA_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {set_out, inc_out, load_out, value_out, data_out} = '0;
    task automatic issue(input logic s, input logic [15:0] v, input logic w, input logic [31:0] d);
        @(negedge clk_in);
        {set_out, inc_out, load_out, value_out, data_out} = {s, !s, w, v, d};
        while (stall_in) @(negedge clk_in);
        @(posedge clk_in);
    endtask
    // Released lines show inverted junk, never the old value
    task automatic rest();
        @(negedge clk_in);
        {set_out, inc_out, load_out} = '0;
        value_out = ~value_out;
        data_out = ~data_out;
    endtask
endmodule // bdm_seq_model

// >>> testbench/bdm_timing_monitor.sv
`include "bdm_defs.vh"
module bdm_timing_monitor (
    // Clock, reset and requests
    input wire                   clk_in,
    input wire                   reset_in,
    input wire                   fast_mode_in,
    input wire                   addr_set_in,
    input wire                   addr_inc_in,
    input wire                   addr_dec_in,
    input wire [`BDM_ADDR_W-1:0] addr_value_in,
    input wire                   refresh_req_in,
    input wire                   host_dma_req_in,
    input wire                   second_io_channel_req_in,
    // Results
    input wire [`BDM_ADDR_W-1:0] memory_address_register_out,
    input wire                   stall_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire       req  = addr_set_in | addr_inc_in | addr_dec_in;
    wire       ev   = refresh_req_in | host_dma_req_in | second_io_channel_req_in;
    wire [3:0] bank = {addr_value_in[`BDM_PAIR_HI:`BDM_PAIR_LO], addr_value_in[`BDM_ODD_BIT]};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_same;
        addr_set_in && !stall_out ##1 addr_set_in && !stall_out && addr_value_in == $past(addr_value_in);
    endsequence
    sequence s_diff;
        fast_mode_in && addr_set_in && !stall_out && !ev ##1
        fast_mode_in && addr_set_in && !stall_out && !ev && bank != $past(bank);
    endsequence
    property p_refresh; refresh_req_in && !stall_out |=> stall_out [*3]; endproperty
    property p_host; host_dma_req_in && !stall_out && !fast_mode_in |=> stall_out; endproperty
    property p_io; second_io_channel_req_in && !stall_out |=> stall_out; endproperty
    property p_set; addr_set_in && !stall_out ##1 !stall_out |-> memory_address_register_out == $past(addr_value_in);
    endproperty
    property p_inc; addr_inc_in && !addr_set_in && !stall_out ##1 !stall_out
        |-> memory_address_register_out == $past(memory_address_register_out) + 16'h1; endproperty
    property p_hold; $changed(memory_address_register_out) |-> $past(req) || $past(stall_out); endproperty
    property p_same; s_same |=> stall_out; endproperty
    property p_diff; s_diff |=> !stall_out; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh stall too short");
    a_host: assert property (p_host) else $error("host access without stall");
    a_io: assert property (p_io) else $error("channel access without stall");
    a_set: assert property (p_set) else $error("address not loaded");
    a_inc: assert property (p_inc) else $error("address not stepped");
    a_hold: assert property (p_hold) else $error("address moved on its own");
    a_same: assert property (p_same) else $error("same bank not spaced");
    a_diff: assert property (p_diff) else $error("fast interleave stalled");
    c_refresh: cover property (refresh_req_in && !stall_out ##1 stall_out);
    c_same: cover property (s_same);
    c_diff: cover property (s_diff);
endmodule // bdm_timing_monitor

bind bdm_timing bdm_timing_monitor i_monitor (.clk_in(clk_in), .reset_in(reset_in), .fast_mode_in(fast_mode_in),
    .addr_set_in(addr_set_in), .addr_inc_in(addr_inc_in), .addr_dec_in(addr_dec_in), .addr_value_in(addr_value_in),
    .refresh_req_in(refresh_req_in), .host_dma_req_in(host_dma_req_in),
    .second_io_channel_req_in(second_io_channel_req_in),
    .memory_address_register_out(memory_address_register_out), .stall_out(stall_out));

// >>> testbench/bdm_timing_test.sv
`include "bdm_defs.vh"
module bdm_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk_in = 0, reset_in = 1, fast = 0, refresh = 0, host = 0, io = 0;
    logic [`BDM_ADDR_W-1:0] host_addr = 0, io_addr = 0, value, mar;
    logic [`BDM_DATA_W-1:0] wdata, rdata, last_rd = 0, d0, d1;
    logic                   set, inc, load, stall, dec = 0;
    logic [31:0]            exp_q[$];
    int                     failures = 0, compares = 0, seed = 83288, stall_cnt = 0, lefto = 0, h;
    int                     pen[5][2] = '{'{8, 8}, '{4, 2}, '{6, 4}, '{5, 4}, '{7, 6}};
    localparam logic [15:0] base_addr = 16'h4010;
    always #12.5 clk_in = ~clk_in;
    bdm_seq_model i_seq (.clk_in(clk_in), .stall_in(stall), .set_out(set), .inc_out(inc), .value_out(value),
        .load_out(load), .data_out(wdata));
    bdm_timing i_dut (.clk_in(clk_in), .reset_in(reset_in), .fast_mode_in(fast), .addr_set_in(set),
        .addr_inc_in(inc), .addr_dec_in(dec), .addr_value_in(value), .write_load_in(load),
        .memory_write_input_in(wdata), .refresh_req_in(refresh), .host_dma_req_in(host),
        .host_dma_addr_in(host_addr), .second_io_channel_req_in(io), .second_io_channel_addr_in(io_addr),
        .memory_address_register_out(mar), .memory_read_output_out(rdata), .stall_out(stall));
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check_word(input string name, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic check_count(input string name, input int e, g);
        check_word(name, e, g);
    endtask
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Any change of read data must be the oldest expected word
    always @(posedge clk_in) begin
        if (stall) stall_cnt++;
        #1;
        if (!reset_in && rdata !== last_rd) begin
            check_word("read", exp_q.size() ? exp_q.pop_front() : 32'bx, rdata);
            last_rd = rdata;
        end
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic pulse(input int e, input logic [15:0] a);
        @(negedge clk_in);
        {host_addr, io_addr} = {a, a};
        {refresh, host, io} = {e == 0, e == 1 || e == 2, e > 2};
        @(negedge clk_in);
        {refresh, host, io} = 3'h0;
        {host_addr, io_addr} = ~{a, a};
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 0;
        check_word("reset", 0, {rdata[14:0], mar, stall});
        d0 = $random(seed);
        d1 = $random(seed);
        fast = 1;
        i_seq.issue(1, base_addr, 1, d0);
        i_seq.issue(0, 0, 1, d1);
        i_seq.rest();
        check_word("address", base_addr + 16'h1, mar);
        repeat (3) @(negedge clk_in);
        exp_q.push_back(d0);
        i_seq.issue(1, base_addr, 0, 0);
        i_seq.rest();
        @(posedge clk_in);
        #1 check_word("early", 0, rdata);
        @(posedge clk_in);
        #1 check_word("latency", d0, rdata);
        // Each event after an interleaved or a same-bank access pair
        for (int ni = 0; ni < 2; ni++)
            for (int f = 0; f < 2; f++)
                for (int e = 0; e < 5; e++) begin
                    fast = f;
                    if (!ni) exp_q.push_back(d1);
                    if (!ni) exp_q.push_back(d0);
                    i_seq.issue(1, base_addr + 16'(!ni), 0, 0);
                    i_seq.issue(1, base_addr, 0, 0);
                    i_seq.rest();
                    repeat (6) @(negedge clk_in);
                    stall_cnt = 0;
                    pulse(e, e % 2 ? base_addr ^ 16'ha000 : base_addr + 16'h2);
                    repeat (8) @(negedge clk_in);
                    h = lefto + pen[e][f] - 2 * ni;
                    lefto = h % 2;
                    check_count("penalty", h / 2, stall_cnt);
                end
        for (int f = 0; f < 2; f++) begin
            fast = f;
            stall_cnt = 0;
            i_seq.issue(1, base_addr, 0, 0);
            i_seq.issue(1, base_addr, 0, 0);
            i_seq.rest();
            repeat (6) @(negedge clk_in);
            check_count("bank wait", 2 - f, stall_cnt);
        end
        // Step down reads the word just below, written first
        i_seq.issue(1, base_addr - 16'h1, 1, d1);
        i_seq.issue(1, base_addr, 0, 0);
        i_seq.rest();
        repeat (3) @(negedge clk_in);
        exp_q.push_back(d1);
        dec = 1;
        @(negedge clk_in);
        dec = 0;
        check_word("step down", base_addr - 16'h1, mar);
        repeat (4) @(negedge clk_in);
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        failures++;
        complete_run();
    end
endmodule // bdm_timing_test
